// ==== src/pio_pkg.sv ====
// Constants, register map and carrier types for the port 3 / port 4 pin block.
// Assumes a 32-bit AXI4-Lite register bus with a 20-bit byte address.
package pio_pkg;

    // ==========================================================
    // Bus widths and responses
    localparam int          PIO_ADDR_W   = 20;
    localparam int          PIO_IDX_W    = 18;
    localparam logic [1:0]  PIO_RESP_OK  = 2'h0;
    localparam logic [1:0]  PIO_RESP_ERR = 2'h2;
    localparam logic [31:0] PIO_RD_ZERO  = 32'h0000_0000;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [17:0] PIO_IDX_P4_DATA = 18'h0ffd7;
    localparam logic [17:0] PIO_IDX_P4_DIR  = 18'h0ffe7;
    localparam logic [17:0] PIO_IDX_P3_DATA = 18'h0ffd6;
    localparam logic [17:0] PIO_IDX_P3_DIR  = 18'h0ffe6;
    localparam logic [17:0] PIO_IDX_P3_PU   = 18'h0ffe0;
    localparam logic [17:0] PIO_IDX_P3_SEL  = 18'h0ffe1;

    // ==========================================================
    // Reset values and field layout
    localparam logic [7:0] PIO_P4_RESET    = 8'hf8;
    localparam logic [7:0] PIO_P3_RESET    = 8'h00;
    localparam logic [7:0] PIO_ALL_ONES    = 8'hff;
    localparam logic [7:0] PIO_P4_RW_MASK  = 8'h07;
    localparam int         PIO_P4_IN_BIT   = 3;
    localparam int         PIO_SEL_PWM     = 0;
    localparam int         PIO_SEL_CNTDIR  = 1;
    localparam int         PIO_SEL_RSTOUT  = 2;
    localparam int         PIO_SEL_EVHIGH  = 6;
    localparam int         PIO_SEL_EVLOW   = 7;

    // ==========================================================
    // Operating modes and pin carriers
    typedef enum logic [2:0] {
        PIO_MODE_ACTIVE,
        PIO_MODE_SUBACTIVE,
        PIO_MODE_SLEEP,
        PIO_MODE_SUBSLEEP,
        PIO_MODE_WATCH,
        PIO_MODE_STANDBY
    } pio_mode_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } pio_p3_drive_t;

    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } pio_p4_drive_t;

endpackage

// ==== src/pio_port_regs.sv ====
// Port 3 pin control and port 4 registers behind an AXI4-Lite slave.
// Assumes one clock, an active-low asynchronous reset, and pins that
// arrive asynchronously; the pad ring resolves pins from out/oe/pull-up.
//
// What this block does
// - Select bit hands pin to peripheral on pins 0, 1, 2, 6 and 7; bits 3 to 5 do nothing.
// - Input with pull-up bit enables pull-up.
// - Pull-up off whenever direction bit is one; pins 0 and 2 driven by peripheral keep it.
// - All port 3 pull-ups off after reset.
// - Pins float, hold or work per mode.
// - Standby pin with pull-up reads high.
// - Port 4 data register, read/write, H'F8.
// - Port 4 direction register, write-only, H'F8.
// - Port 4 read: outputs stored, inputs live.
// - Direction one is output, zero input.
// - Port 4 direction reads all ones.
`timescale 1ns/1ps

module pio_port_regs
    import pio_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic [PIO_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [PIO_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire pio_mode_t             power_mode,
    input  wire logic                  pwm_level,
    input  wire logic                  reset_out_level,
    input  wire logic [7:0]            p3_pin_in,
    input  wire logic [3:0]            p4_pin_in,
    output pio_p3_drive_t              p3_drive,
    output pio_p4_drive_t              p4_drive,
    output logic                       count_direction_input,
    output logic                       async_event_high_input,
    output logic                       async_event_low_input
);

    // ==========================================================
    // Address decode
    function automatic logic [1:0] pio_hit(input logic [PIO_ADDR_W-1:0] a);
        logic [PIO_IDX_W-1:0] idx;
        idx = a[PIO_ADDR_W-1:2];
        pio_hit = (idx == PIO_IDX_P4_DATA || idx == PIO_IDX_P4_DIR
                || idx == PIO_IDX_P3_DATA || idx == PIO_IDX_P3_DIR
                || idx == PIO_IDX_P3_PU   || idx == PIO_IDX_P3_SEL)
                ? PIO_RESP_OK : PIO_RESP_ERR;
    endfunction

    // ==========================================================
    // Pin synchronisers
    logic [7:0] p3_meta_reg;
    logic [7:0] p3_sync_reg;
    logic [3:0] p4_meta_reg;
    logic [3:0] p4_sync_reg;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            p3_meta_reg <= PIO_P3_RESET;
            p3_sync_reg <= PIO_P3_RESET;
            p4_meta_reg <= 4'h0;
            p4_sync_reg <= 4'h0;
        end
        else
        begin
            p3_meta_reg <= p3_pin_in;
            p3_sync_reg <= p3_meta_reg;
            p4_meta_reg <= p4_pin_in;
            p4_sync_reg <= p4_meta_reg;
        end
    end

    // ==========================================================
    // AXI4-Lite write path
    logic                  aw_full_reg;
    logic                  w_full_reg;
    logic [PIO_ADDR_W-1:0] aw_addr_reg;
    logic [31:0]           w_data_reg;
    logic                  w_lane0_reg;
    logic                  commit;
    logic [PIO_IDX_W-1:0]  wr_idx;

    assign commit = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_idx = aw_addr_reg[PIO_ADDR_W-1:2];

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            aw_addr_reg   <= '0;
            w_data_reg    <= 32'h0000_0000;
            w_lane0_reg   <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= PIO_RESP_OK;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_lane0_reg  <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (commit)
            begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= pio_hit(aw_addr_reg);
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Registers and their next values
    logic [7:0] p4_data_reg, p4_data_next;
    logic [7:0] p4_dir_reg, p4_dir_next;
    logic [7:0] p3_data_reg, p3_data_next;
    logic [7:0] p3_dir_reg, p3_dir_next;
    logic [7:0] p3_pu_reg, p3_pu_next;
    logic [7:0] p3_sel_reg, p3_sel_next;
    logic       wr_ok;

    // Only the low byte lane holds register bits; other lanes are ignored.
    assign wr_ok = commit && w_lane0_reg;

    always_comb
    begin
        p4_data_next = p4_data_reg;
        p4_dir_next  = p4_dir_reg;
        p3_data_next = p3_data_reg;
        p3_dir_next  = p3_dir_reg;
        p3_pu_next   = p3_pu_reg;
        p3_sel_next  = p3_sel_reg;
        if (wr_ok)
        begin
            case (wr_idx)
                PIO_IDX_P4_DATA: p4_data_next = (p4_data_reg & ~PIO_P4_RW_MASK)
                                              | (w_data_reg[7:0] & PIO_P4_RW_MASK);
                PIO_IDX_P4_DIR:  p4_dir_next  = (p4_dir_reg & ~PIO_P4_RW_MASK)
                                              | (w_data_reg[7:0] & PIO_P4_RW_MASK);
                PIO_IDX_P3_DATA: p3_data_next = w_data_reg[7:0];
                PIO_IDX_P3_DIR:  p3_dir_next  = w_data_reg[7:0];
                PIO_IDX_P3_PU:   p3_pu_next   = w_data_reg[7:0];
                PIO_IDX_P3_SEL:  p3_sel_next  = w_data_reg[7:0];
                default:         p3_sel_next  = p3_sel_reg;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            p4_data_reg <= PIO_P4_RESET;
            p4_dir_reg  <= PIO_P4_RESET;
            p3_data_reg <= PIO_P3_RESET;
            p3_dir_reg  <= PIO_P3_RESET;
            p3_pu_reg   <= PIO_P3_RESET;
            p3_sel_reg  <= PIO_P3_RESET;
        end
        else
        begin
            p4_data_reg <= p4_data_next;
            p4_dir_reg  <= p4_dir_next;
            p3_data_reg <= p3_data_next;
            p3_dir_reg  <= p3_dir_next;
            p3_pu_reg   <= p3_pu_next;
            p3_sel_reg  <= p3_sel_next;
        end
    end

    // ==========================================================
    // AXI4-Lite read path
    logic [7:0]           rd_byte;
    logic [PIO_IDX_W-1:0] rd_idx;

    assign rd_idx = s_axi_araddr[PIO_ADDR_W-1:2];

    always_comb
    begin
        case (rd_idx)
            PIO_IDX_P4_DATA: rd_byte = {p4_data_reg[7:PIO_P4_IN_BIT+1],
                                        p4_sync_reg[PIO_P4_IN_BIT],
                                        (p4_data_reg[2:0] & p4_dir_reg[2:0])
                                        | (p4_sync_reg[2:0] & ~p4_dir_reg[2:0])};
            PIO_IDX_P4_DIR:  rd_byte = PIO_ALL_ONES;
            PIO_IDX_P3_DATA: rd_byte = (p3_data_reg & p3_dir_reg)
                                     | (p3_sync_reg & ~p3_dir_reg);
            PIO_IDX_P3_DIR:  rd_byte = p3_dir_reg;
            PIO_IDX_P3_PU:   rd_byte = p3_pu_reg;
            PIO_IDX_P3_SEL:  rd_byte = p3_sel_reg;
            default:         rd_byte = PIO_P3_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= PIO_RD_ZERO;
            s_axi_rresp   <= PIO_RESP_OK;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= pio_hit(s_axi_araddr);
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // Pin drive
    // Drive is computed from the next register values so that a new select
    // or direction reaches the pin at the very edge that stores it, while
    // the pins still come straight from flip-flops.
    pio_p3_drive_t p3_next;
    pio_p4_drive_t p4_next;

    always_comb
    begin
        p3_next.out = p3_data_next;
        p3_next.oe  = p3_dir_next;
        p3_next.oe[PIO_SEL_CNTDIR] = p3_dir_next[PIO_SEL_CNTDIR]
                                   && !p3_sel_next[PIO_SEL_CNTDIR];
        p3_next.oe[PIO_SEL_EVHIGH] = p3_dir_next[PIO_SEL_EVHIGH]
                                   && !p3_sel_next[PIO_SEL_EVHIGH];
        p3_next.oe[PIO_SEL_EVLOW]  = p3_dir_next[PIO_SEL_EVLOW]
                                   && !p3_sel_next[PIO_SEL_EVLOW];
        if (p3_sel_next[PIO_SEL_PWM])
        begin
            p3_next.oe[PIO_SEL_PWM]  = 1'b1;
            p3_next.out[PIO_SEL_PWM] = pwm_level;
        end
        if (p3_sel_next[PIO_SEL_RSTOUT])
        begin
            p3_next.oe[PIO_SEL_RSTOUT]  = 1'b1;
            p3_next.out[PIO_SEL_RSTOUT] = reset_out_level;
        end
        p3_next.pu  = p3_pu_next & ~p3_dir_next;
        p4_next.out = p4_data_next[2:0];
        p4_next.oe  = p4_dir_next[2:0];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            p3_drive <= '0;
            p4_drive <= '0;
        end
        else
        begin
            case (power_mode)
                PIO_MODE_ACTIVE, PIO_MODE_SUBACTIVE:
                begin
                    p3_drive <= p3_next;
                    p4_drive <= p4_next;
                end
                PIO_MODE_STANDBY:
                begin
                    p3_drive.out <= '0;
                    p3_drive.oe  <= '0;
                    p3_drive.pu  <= p3_next.pu;
                    p4_drive     <= '0;
                end
                // Sleep, subsleep and watch keep the last drive.
                default:
                begin
                    p3_drive <= p3_drive;
                    p4_drive <= p4_drive;
                end
            endcase
        end
    end

    // ==========================================================
    // Peripheral inputs taken from port 3
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_direction_input  <= 1'b0;
            async_event_high_input <= 1'b0;
            async_event_low_input  <= 1'b0;
        end
        else
        begin
            count_direction_input  <= p3_sel_reg[PIO_SEL_CNTDIR]
                                   && p3_sync_reg[PIO_SEL_CNTDIR];
            async_event_high_input <= p3_sel_reg[PIO_SEL_EVHIGH]
                                   && p3_sync_reg[PIO_SEL_EVHIGH];
            async_event_low_input  <= p3_sel_reg[PIO_SEL_EVLOW]
                                   && p3_sync_reg[PIO_SEL_EVLOW];
        end
    end

endmodule // pio_port_regs

// ==== verification/pio_chk_assertions.sv ====
// Checker for the port pin block, bound to every pio_port_regs instance.
// Assumes the design's port names and the pio_pkg carrier types.
`timescale 1ns/1ps
module pio_chk
    import pio_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic [PIO_ADDR_W-1:0] s_axi_araddr,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire logic [31:0]           s_axi_rdata,
    input wire pio_mode_t             power_mode,
    input wire logic [7:0]            p3_pin_in,
    input wire pio_p3_drive_t         p3_drive,
    input wire pio_p4_drive_t         p4_drive,
    input wire logic                  count_direction_input
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ==========
    // Pin states
    // reset leaves pins off
    AST_RST_OFF: assert property ($rose(rst_b) |-> p3_drive == '0 && p4_drive == '0)
        else $error("pins not off at reset release");
    // no pull-up on output
    // Pins 0 and 2 are left out: their peripheral may drive with the direction bit clear.
    AST_PU_NOT_DRIVEN: assert property ((p3_drive.pu & p3_drive.oe & 8'hfa) == 8'h00)
        else $error("pull-up on while pin drives");
    AST_STBY_FLOAT: assert property (power_mode == PIO_MODE_STANDBY |=>
        p3_drive.oe == 8'h00 && p3_drive.out == 8'h00 && p4_drive.oe == 3'h0)
        else $error("pins driven in standby");
    AST_LP_HOLD: assert property (power_mode inside {PIO_MODE_SLEEP, PIO_MODE_SUBSLEEP,
        PIO_MODE_WATCH} |=> $stable(p3_drive) && $stable(p4_drive))
        else $error("pin state changed in a holding mode");
    AST_CNTDIR_SRC: assert property (count_direction_input |-> $past(p3_pin_in[1], 3))
        else $error("count direction high without pin high");

    // ==========
    // Register bus
    // direction reads ones
    AST_DIR_ONES: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == {PIO_IDX_P4_DIR, 2'b00} |=> s_axi_rvalid && s_axi_rdata[7:0] == 8'hff)
        else $error("direction register did not read all ones");
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_BUSY_REFUSES: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready while response pending");
endmodule // pio_chk

bind pio_port_regs pio_chk chk_u (.clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .power_mode(power_mode), .p3_pin_in(p3_pin_in), .p3_drive(p3_drive),
    .p4_drive(p4_drive), .count_direction_input(count_direction_input));

// ==== verification/pio_pin_model.sv ====
// Board-side model of the port 3 and port 4 pins.
// Assumes the bench says which pins an outside source drives.
`timescale 1ns/1ps
module pio_pin_model
    import pio_pkg::*;
(
    input  wire logic          clk,
    input  wire pio_p3_drive_t p3_drive,
    input  wire pio_p4_drive_t p4_drive,
    input  wire logic [7:0]    e3_en,
    input  wire logic [7:0]    e3_val,
    input  wire logic [3:0]    e4_en,
    input  wire logic [3:0]    e4_val,
    output logic [7:0]         p3_pin,
    output logic [3:0]         p4_pin
);
    // ==========
    // Pin levels
    // A floating pin toggles so that no settled value can pass for a level.
    logic flip_reg = 1'b0;
    always @(posedge clk)
        flip_reg <= ~flip_reg;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            p3_pin[i] = p3_drive.oe[i] ? p3_drive.out[i] : e3_en[i] ? e3_val[i]
                      : (p3_drive.pu[i] | flip_reg);
        for (int i = 0; i < 3; i++)
            p4_pin[i] = p4_drive.oe[i] ? p4_drive.out[i] : e4_en[i] ? e4_val[i] : flip_reg;
        p4_pin[3] = e4_en[3] ? e4_val[3] : flip_reg;
    end
endmodule // pio_pin_model

// ==== verification/tb.sv ====
// Bench for the port 3 pin control and port 4 register block.
// Assumes pio_pkg, the pin model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb
    import pio_pkg::*;
;
    logic                  clk, rst_b, pwm_lv, rso_lv, cdi, aeh, ael;
    logic                  awvalid, awready, wvalid, wready, bvalid, bready;
    logic                  arvalid, arready, rvalid, rready;
    logic [PIO_ADDR_W-1:0] awaddr, araddr;
    logic [31:0]           wdata, rdata;
    logic [1:0]            bresp, rresp;
    logic [7:0]            p3_pin, e3_en, e3_val, exp_oe;
    logic [3:0]            p4_pin, e4_en, e4_val;
    pio_mode_t             mode;
    pio_p3_drive_t         p3d;
    pio_p4_drive_t         p4d;
    int                    fails, checks_done;

    pio_port_regs dut_u (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .power_mode(mode), .pwm_level(pwm_lv), .reset_out_level(rso_lv), .p3_pin_in(p3_pin),
        .p4_pin_in(p4_pin), .p3_drive(p3d), .p4_drive(p4d), .count_direction_input(cdi),
        .async_event_high_input(aeh), .async_event_low_input(ael));
    pio_pin_model pins_u (.clk(clk), .p3_drive(p3d), .p4_drive(p4d), .e3_en(e3_en),
        .e3_val(e3_val), .e4_en(e4_en), .e4_val(e4_val), .p3_pin(p3_pin), .p4_pin(p4_pin));

    // ==========
    // Shared tasks
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Address and data go out together; each is dropped once taken.
    task automatic wr(input logic [17:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic ok;
        ok = 1'b0;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40 && !ok; n++)
        begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                ok = 1'b1;
                chk(bresp, er);
            end
        end
        bready <= 1'b0;
        if (!ok)
        begin
            fails++;
            complete_run();
        end
        @(posedge clk);
    endtask

    task automatic rd(input logic [17:0] idx, input logic [31:0] exp, input logic [1:0] er);
        logic ok;
        ok = 1'b0;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40 && !ok; n++)
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                ok = 1'b1;
                chk(rdata, exp);
                chk(rresp, er);
            end
        end
        rready <= 1'b0;
        if (!ok)
        begin
            fails++;
            complete_run();
        end
        @(posedge clk);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==========
    // Main sequence
    initial
    begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready, pwm_lv, rso_lv} = 8'h02;
        {awaddr, araddr, wdata, e3_en, e3_val} = '0;
        {e4_en, e4_val} = 8'hf5;
        mode = PIO_MODE_ACTIVE;
        fails = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk(p3d, 32'h0);
        rd(PIO_IDX_P4_DATA, 32'hf5, PIO_RESP_OK);
        rd(PIO_IDX_P4_DIR, 32'hff, PIO_RESP_OK);
        wr(PIO_IDX_P4_DATA, 8'h02, PIO_RESP_OK);
        wr(PIO_IDX_P4_DIR, 8'h03, PIO_RESP_OK);
        chk(p4d, 32'h13);
        rd(PIO_IDX_P4_DIR, 32'hff, PIO_RESP_OK);
        rd(PIO_IDX_P4_DATA, 32'hf6, PIO_RESP_OK);
        wr(PIO_IDX_P4_DIR, 8'hff, PIO_RESP_OK);
        chk(p4d.oe, 32'h7);
        rd(PIO_IDX_P4_DATA, 32'hf2, PIO_RESP_OK);
        wr(18'h00100, 8'h55, PIO_RESP_ERR);
        rd(18'h00100, 32'h0, PIO_RESP_ERR);
        wr(PIO_IDX_P3_PU, 8'hff, PIO_RESP_OK);
        chk(p3d.pu, 32'hff);
        wr(PIO_IDX_P3_DIR, 8'hf0, PIO_RESP_OK);
        chk(p3d.pu, 32'h0f);
        wr(PIO_IDX_P3_DATA, 8'ha5, PIO_RESP_OK);
        chk(p3d.out, 32'ha5);
        rd(PIO_IDX_P3_DATA, 32'haf, PIO_RESP_OK);
        wr(PIO_IDX_P3_SEL, 8'h05, PIO_RESP_OK);
        chk({p3d.oe[2:0], p3d.out[2], p3d.out[0]}, 32'h15);
        e3_en <= 8'hc2;
        e3_val <= 8'hc2;
        wr(PIO_IDX_P3_SEL, 8'hc2, PIO_RESP_OK);
        repeat (4) @(posedge clk);
        chk({cdi, aeh, ael, p3d.oe[7:6], p3d.oe[1]}, 32'h38);
        e3_val <= 8'h00;
        repeat (4) @(posedge clk);
        chk({cdi, aeh, ael}, 32'h0);
        e3_val <= 8'hc2;
        wr(PIO_IDX_P3_SEL, 8'h00, PIO_RESP_OK);
        repeat (4) @(posedge clk);
        chk({cdi, aeh, ael, p3d.oe[7:6], p3d.oe[2:0]}, 32'h18);
        exp_oe = 8'hf0;
        // Only the two running modes let a direction write reach the output enables.
        for (int m = 0; m < 5; m++)
        begin
            mode <= pio_mode_t'(m);
            wr(PIO_IDX_P3_DIR, 8'h10 + 8'(m), PIO_RESP_OK);
            if (m < 2)
                exp_oe = 8'h10 + 8'(m);
            chk(p3d.oe, exp_oe);
        end
        e3_en <= 8'h00;
        mode <= PIO_MODE_STANDBY;
        repeat (2) @(posedge clk);
        chk({p3d.oe, p3d.out, p4d.oe}, 32'h0);
        chk(p3d.pu, 32'heb);
        chk(p3_pin & 8'heb, 32'heb);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk({p3d, p4d}, 32'h0);
        rst_b <= 1'b1;
        mode <= PIO_MODE_ACTIVE;
        repeat (3) @(posedge clk);
        rd(PIO_IDX_P4_DATA, 32'hf5, PIO_RESP_OK);
        complete_run();
    end
endmodule // tb
